// *** src/cswc_ctrl.sv ***
// Channel power, suspend/wake, send-now and buffer timeout control.
// Assumes synchronous inputs from the USB engine and channel logic.
`timescale 1ns/1ns
module cswc_ctrl
	import cswc_pkg::*;
#(
	parameter int MS_CYCLES     = MS_CYCLES_DEF,
	parameter int SETTLE_CYCLES = SETTLE_CYC_DEF,
	parameter int IO_LINES      = 8
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              ext_reset_n,
	input  wire logic              usb_enumerated,
	input  wire logic              usb_suspend,
	input  wire logic              send_now_wake_n,
	input  wire logic              rx_pending,
	input  wire logic              bulk_in_req,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [DATA_W-1:0]      reg_rdata,
	output logic                   power_switch_n,
	output logic [IO_LINES-1:0]    io_pulldown,
	output logic                   resume_req,
	output logic                   short_pkt,
	output logic                   iso_mode,
	output logic                   enum_allow,
	output logic                   clear_out_n
);
	localparam int SET_W = $clog2(SETTLE_CYCLES + 1);
	localparam logic [SET_W-1:0] SET_LAST = SET_W'(SETTLE_CYCLES - 1);

	// Block reset: power-on reset or the external pin
	logic rst_int;
	assign rst_int = srst | ~ext_reset_n;

	// Configuration registers
	logic [CTRL_W-1:0] ctrl_r;
	logic [CTRL_W-1:0] ctrl_nxt;
	logic [TMO_W-1:0]  tmo_r;
	logic [TMO_W-1:0]  tmo_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	// Power state and settle timer
	cswc_pstate_t      state_r;
	cswc_pstate_t      state_nxt;
	logic [SET_W-1:0]  set_cnt_r;
	logic [SET_W-1:0]  set_cnt_nxt;
	logic              enum_allow_r;
	logic              enum_allow_nxt;
	logic              pwr_n_r;
	logic              pwr_n_nxt;
	logic [IO_LINES-1:0] pd_r;
	logic [IO_LINES-1:0] pd_nxt;
	logic              iso_r;
	logic              iso_nxt;

	// Wake strobe and short packet handling
	logic              wake_prev_r;
	logic              wake_fall;
	logic              resume_r;
	logic              resume_nxt;
	logic              flush_r;
	logic              flush_nxt;
	logic              short_r;
	logic              short_nxt;
	logic              tmo_run;
	logic              tmo_exp;

	// Reset output stretch
	logic [CLR_CNT_W-1:0] clr_cnt_r;
	logic [CLR_CNT_W-1:0] clr_cnt_nxt;
	logic                 clr_n_r;
	logic                 clr_n_nxt;

	// Register port
	always_comb begin
		ctrl_nxt  = ctrl_r;
		tmo_nxt   = tmo_r;
		rdata_nxt = '0;
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					ctrl_nxt = reg_wdata[CTRL_W-1:0];
				end
				OFS_TIMEOUT: begin
					// Zero would mean no timeout; clamp to shortest
					if (reg_wdata[TMO_W-1:0] < TMO_MIN_MS)
						tmo_nxt = TMO_MIN_MS;
					else
						tmo_nxt = reg_wdata[TMO_W-1:0];
				end
				default: begin
					ctrl_nxt = ctrl_r;
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL:    rdata_nxt[CTRL_W-1:0] = ctrl_r;
				OFS_TIMEOUT: rdata_nxt[TMO_W-1:0]  = tmo_r;
				OFS_STATUS: begin
					rdata_nxt[STAT_STATE_LSB +: $bits(state_r)] = state_r;
					rdata_nxt[STAT_FLUSH_BIT]      = flush_r;
					rdata_nxt[STAT_TMO_BIT]        = tmo_exp;
					rdata_nxt[STAT_SUSP_BIT]       = usb_suspend;
					rdata_nxt[STAT_ENUM_BIT]       = enum_allow_r;
				end
				default:     rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst_int) begin
			ctrl_r  <= CTRL_RST;
			tmo_r   <= TMO_RST_MS;
			rdata_r <= '0;
		end else begin
			ctrl_r  <= ctrl_nxt;
			tmo_r   <= tmo_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Power state machine
	always_comb begin
		state_nxt      = state_r;
		set_cnt_nxt    = set_cnt_r;
		enum_allow_nxt = enum_allow_r;
		case (state_r)
			PS_SETTLE: begin
				set_cnt_nxt = set_cnt_r + SET_W'(1);
				if (set_cnt_r == SET_LAST) begin
					state_nxt      = PS_WAIT_ENU;
					enum_allow_nxt = 1'b1;
				end
			end
			PS_WAIT_ENU: begin
				if (usb_enumerated && !usb_suspend)
					state_nxt = PS_ON;
			end
			PS_ON: begin
				if (usb_suspend)
					state_nxt = PS_SUSPEND;
				else if (!usb_enumerated)
					state_nxt = PS_WAIT_ENU;
			end
			PS_SUSPEND: begin
				if (!usb_suspend)
					state_nxt = usb_enumerated ? PS_ON : PS_WAIT_ENU;
			end
			default: begin
				state_nxt = PS_SETTLE;
			end
		endcase
		// Outputs follow the next state and control so they line up with state_r and ctrl_r
		pwr_n_nxt = (state_nxt != PS_ON);
		iso_nxt   = ctrl_nxt[CTRL_ISO_BIT];
	end

	// Pull-down per channel line
	for (genvar i = 0; i < IO_LINES; i++) begin : g_pd
		assign pd_nxt[i] = ctrl_nxt[CTRL_PULLDOWN_BIT] & pwr_n_nxt;
	end

	always_ff @(posedge clk) begin
		if (rst_int) begin
			state_r      <= PS_SETTLE;
			set_cnt_r    <= '0;
			enum_allow_r <= 1'b0;
			pwr_n_r      <= 1'b1;
			pd_r         <= '0;
			iso_r        <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			set_cnt_r    <= set_cnt_nxt;
			enum_allow_r <= enum_allow_nxt;
			pwr_n_r      <= pwr_n_nxt;
			pd_r         <= pd_nxt;
			iso_r        <= iso_nxt;
		end
	end

	// Send-now / wake strobe
	assign wake_fall = wake_prev_r & ~send_now_wake_n;
	// Timer restarts on each served request and stops without data
	assign tmo_run = rx_pending & (state_r == PS_ON) & ~bulk_in_req;

	always_comb begin
		resume_nxt = wake_fall & usb_suspend & ctrl_r[CTRL_RWAKE_BIT];
		// A strobe in the serving cycle wins and waits for the next one
		flush_nxt  = (wake_fall & ~usb_suspend) |
			(flush_r & ~bulk_in_req);
		short_nxt  = bulk_in_req & (flush_r | tmo_exp);
	end

	always_ff @(posedge clk) begin
		if (rst_int) begin
			wake_prev_r <= 1'b1;
			resume_r    <= 1'b0;
			flush_r     <= 1'b0;
			short_r     <= 1'b0;
		end else begin
			wake_prev_r <= send_now_wake_n;
			resume_r    <= resume_nxt;
			flush_r     <= flush_nxt;
			short_r     <= short_nxt;
		end
	end

	cswc_ms_timer #(
		.MS_CYCLES (MS_CYCLES),
		.LIM_W     (TMO_W)
	) u_tmo (
		.clk     (clk),
		.srst    (rst_int),
		.run     (tmo_run),
		.limit   (tmo_r),
		.expired (tmo_exp)
	);

	// Reset output: power-on reset only, so the pin is not a loop back
	always_comb begin
		clr_cnt_nxt = clr_cnt_r;
		if (clr_cnt_r != '0)
			clr_cnt_nxt = clr_cnt_r - CLR_CNT_W'(1);
		clr_n_nxt = (clr_cnt_nxt == '0);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			clr_cnt_r <= CLR_CNT_W'(CLR_HOLD_CYC);
			clr_n_r   <= 1'b0;
		end else begin
			clr_cnt_r <= clr_cnt_nxt;
			clr_n_r   <= clr_n_nxt;
		end
	end

	assign reg_rdata      = rdata_r;
	assign power_switch_n = pwr_n_r;
	assign io_pulldown    = pd_r;
	assign resume_req     = resume_r;
	assign short_pkt      = short_r;
	assign iso_mode       = iso_r;
	assign enum_allow     = enum_allow_r;
	assign clear_out_n    = clr_n_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst_int);

	a_pwr_enum_on: assert property (
		state_r == PS_WAIT_ENU && usb_enumerated && !usb_suspend
		|=> !power_switch_n
	) else $error("power switch not on after enumeration");

	a_pwr_susp_off: assert property (
		usb_suspend |=> power_switch_n
	) else $error("power switch on during suspend");

	a_pulldown_off: assert property (
		io_pulldown == {IO_LINES{ctrl_r[CTRL_PULLDOWN_BIT] & power_switch_n}}
	) else $error("pull-down does not follow power and option");

	a_wake_resume: assert property (
		wake_fall && usb_suspend && ctrl_r[CTRL_RWAKE_BIT]
		|=> resume_req ##1 !resume_req
	) else $error("wake strobe gave no single resume pulse");

	a_resume_cause: assert property (
		resume_req |-> $past(usb_suspend)
	) else $error("resume request while not suspended");

	a_flush_short: assert property (
		wake_fall && !usb_suspend ##1 bulk_in_req |=> short_pkt
	) else $error("send-now strobe not served as short packet");

	a_tmo_range: assert property (
		tmo_r >= TMO_MIN_MS
	) else $error("buffer timeout below one millisecond");

	a_iso_select: assert property (
		iso_mode == ctrl_r[CTRL_ISO_BIT]
	) else $error("transfer type does not follow its control bit");

	a_settle_gate: assert property (
		!power_switch_n |-> enum_allow && state_r != PS_SETTLE
	) else $error("power on before clock settle");

	a_tmo_short: assert property (
		bulk_in_req && tmo_exp |=> short_pkt
	) else $error("expired timeout not served as short packet");

	a_ext_reset: assert property (
		@(posedge clk) disable iff (srst)
		!ext_reset_n |=> state_r == PS_SETTLE && !enum_allow
	) else $error("external reset did not restart the block");

	a_clear_out: assert property (
		@(posedge clk) disable iff (1'b0)
		srst |=> !clear_out_n [*2]
	) else $error("reset output not held after power-on reset");

	c_enum_on: cover property (state_r == PS_WAIT_ENU ##1 state_r == PS_ON);
	c_wake: cover property (resume_req);
	c_flush: cover property (flush_r && bulk_in_req);
	c_timeout: cover property (tmo_exp && bulk_in_req);
endmodule

// *** src/cswc_ms_timer.sv ***
// Millisecond timer that flags expiry after a programmed count.
// Assumes run is held high while timing and dropped to restart.
`timescale 1ns/1ns
module cswc_ms_timer
	import cswc_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF,
	parameter int LIM_W     = TMO_W
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             run,
	input  wire logic [LIM_W-1:0] limit,
	output logic                  expired
);
	localparam int PRE_W = $clog2(MS_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] pre_nxt;
	logic [LIM_W-1:0] ms_r;
	logic [LIM_W-1:0] ms_nxt;
	logic             exp_r;
	logic             exp_nxt;

	always_comb begin
		pre_nxt = '0;
		ms_nxt  = '0;
		exp_nxt = 1'b0;
		if (run) begin
			exp_nxt = exp_r;
			ms_nxt  = ms_r;
			pre_nxt = pre_r + PRE_W'(1);
			if (pre_r == PRE_LAST) begin
				pre_nxt = '0;
				if (!exp_r)
					ms_nxt = ms_r + LIM_W'(1);
			end
			// Expiry stays until run drops, so no short packet is missed
			if (ms_nxt >= limit)
				exp_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pre_r <= '0;
			ms_r  <= '0;
			exp_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			ms_r  <= ms_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign expired = exp_r;
endmodule

// *** src/cswc_pkg.sv ***
// Constants shared by the channel suspend/wake controller files.
// Assumes a single 25 MHz clock and the plain register port.
package cswc_pkg;

	// Clock and time base
	localparam int CLK_PERIOD_NS = 40;
	localparam int TIME_1MS_NS   = 1000000;
	localparam int MS_CYCLES_DEF =
		(TIME_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Oscillator and multiplier settle time before enumeration
	localparam int SETTLE_TIME_US = 1000;
	localparam int SETTLE_CYC_DEF =
		(SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Hold of the reset output after power-on reset ends
	localparam int CLR_HOLD_US  = 10;
	localparam int CLR_HOLD_CYC =
		(CLR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLR_CNT_W    = $clog2(CLR_HOLD_CYC + 1);

	// Register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;

	// Control register fields
	localparam int CTRL_PULLDOWN_BIT = 0;
	localparam int CTRL_RWAKE_BIT    = 1;
	localparam int CTRL_ISO_BIT      = 2;
	localparam int CTRL_W            = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

	// Buffer timeout in milliseconds
	localparam int TMO_W = 8;
	localparam logic [TMO_W-1:0] TMO_MIN_MS = 8'h01;
	localparam logic [TMO_W-1:0] TMO_RST_MS = 8'h10;

	// Status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_FLUSH_BIT = 2;
	localparam int STAT_TMO_BIT   = 3;
	localparam int STAT_SUSP_BIT  = 4;
	localparam int STAT_ENUM_BIT  = 5;

	typedef enum logic [1:0] {
		PS_SETTLE   = 2'b00,
		PS_WAIT_ENU = 2'b01,
		PS_ON       = 2'b10,
		PS_SUSPEND  = 2'b11
	} cswc_pstate_t;

endpackage

// *** testbench/cswc_ctrl_test.sv ***
// Self-checking bench for the channel suspend/wake controller.
// Assumes shortened timer parameters and the host model beside it.
`timescale 1ns/1ns
module cswc_ctrl_test;
	import cswc_pkg::*;
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic              ext_reset_n = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic              power_switch_n;
	logic [7:0]        io_pulldown;
	logic              resume_req;
	logic              short_pkt;
	logic              iso_mode;
	logic              enum_allow;
	logic              clear_out_n;
	logic              usb_enumerated;
	logic              usb_suspend;
	logic              bulk_in_req;
	logic              send_now_wake_n;
	logic              rx_pending;
	logic [DATA_W-1:0] v;
	int                miscompares = 0;
	int                n_checks = 0;
	int                cyc_n = 0;
	int                n_res = 0;
	int                n_sh = 0;
	int                k;
	int                base;

	always #20 clk = ~clk;

	cswc_ctrl #(.MS_CYCLES(10), .SETTLE_CYCLES(20), .IO_LINES(8)) uut (
		.clk(clk), .srst(srst), .ext_reset_n(ext_reset_n),
		.usb_enumerated(usb_enumerated), .usb_suspend(usb_suspend),
		.send_now_wake_n(send_now_wake_n), .rx_pending(rx_pending),
		.bulk_in_req(bulk_in_req), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .power_switch_n(power_switch_n),
		.io_pulldown(io_pulldown), .resume_req(resume_req),
		.short_pkt(short_pkt), .iso_mode(iso_mode),
		.enum_allow(enum_allow), .clear_out_n(clear_out_n)
	);

	cswc_host_model host (
		.clk(clk), .resume_req(resume_req),
		.usb_enumerated(usb_enumerated), .usb_suspend(usb_suspend),
		.bulk_in_req(bulk_in_req), .send_now_wake_n(send_now_wake_n),
		.rx_pending(rx_pending)
	);

	// Pulses stand one cycle, so count them at every edge
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (resume_req === 1'b1) begin
			n_res <= n_res + 1;
		end
		if (short_pkt === 1'b1) begin
			n_sh <= n_sh + 1;
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task at(input int n);
		while (cyc_n < n) @(posedge clk);
		#1;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a, v);
		chk(v, e);
	endtask

	task tally_and_finish();
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		host.usb_enumerated <= 1'b1;
		#1;
		chk(clear_out_n, 1'b0);
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_TIMEOUT, 32'h10);
		rdc(8'h0c, 32'h0);
		chk(power_switch_n, 1'b1);
		k = 0;
		while (enum_allow !== 1'b1 && k < 40) begin
			cyc(1);
			k++;
		end
		// A settle timer that never ends is a failure, not a hang
		if (k >= 40) begin
			miscompares++;
			tally_and_finish();
		end
		chk((cyc_n >= 31 && cyc_n <= 34), 1'b1);
		cyc(2);
		chk(power_switch_n, 1'b0);
		at(257);
		chk(clear_out_n, 1'b0);
		at(268);
		chk(clear_out_n, 1'b1);
		wr(OFS_CTRL, 32'h4);
		cyc(1);
		chk(iso_mode, 1'b1);
		// Unmapped write must leave the control bits alone
		wr(8'h0c, 32'h7);
		rdc(OFS_CTRL, 32'h4);
		host.strobe();
		rdc(OFS_STATUS, 32'h26);
		base = n_sh;
		host.bulk_in();
		cyc(2);
		chk(n_sh, base + 1);
		rdc(OFS_STATUS, 32'h22);
		// Request right behind the strobe is still served short
		base = n_sh;
		fork
			host.strobe();
			begin
				@(posedge clk);
				host.bulk_in();
			end
		join
		cyc(2);
		chk(n_sh, base + 1);
		rdc(OFS_STATUS, 32'h22);
		wr(OFS_TIMEOUT, 32'h0);
		rdc(OFS_TIMEOUT, 32'h1);
		wr(OFS_TIMEOUT, 32'hff);
		rdc(OFS_TIMEOUT, 32'hff);
		wr(OFS_TIMEOUT, 32'h2);
		host.rx_pending <= 1'b1;
		k = 0;
		v = 32'h0;
		while (v[STAT_TMO_BIT] !== 1'b1 && k < 30) begin
			rd(OFS_STATUS, v);
			k++;
		end
		if (k >= 30) begin
			miscompares++;
			tally_and_finish();
		end
		// About 22 cycles of timing at two cycles a read
		chk((k >= 8 && k <= 14), 1'b1);
		base = n_sh;
		host.bulk_in();
		cyc(2);
		chk(n_sh, base + 1);
		host.rx_pending <= 1'b0;
		wr(OFS_CTRL, 32'h1);
		host.usb_suspend <= 1'b1;
		cyc(2);
		chk(power_switch_n, 1'b1);
		chk(io_pulldown, 8'hff);
		chk(iso_mode, 1'b0);
		rdc(OFS_STATUS, 32'h33);
		base = n_res;
		host.strobe();
		cyc(3);
		chk(n_res, base);
		wr(OFS_CTRL, 32'h3);
		host.strobe();
		cyc(3);
		chk(n_res, base + 1);
		cyc(2);
		chk(power_switch_n, 1'b0);
		chk(io_pulldown, 8'h00);
		@(posedge clk);
		ext_reset_n <= 1'b0;
		cyc(2);
		chk(power_switch_n, 1'b1);
		chk(clear_out_n, 1'b1);
		@(posedge clk);
		ext_reset_n <= 1'b1;
		rdc(OFS_CTRL, 32'h0);
		tally_and_finish();
	end
endmodule

// *** testbench/cswc_host_model.sv ***
// USB host and channel peripheral model facing the suspend/wake block.
// Assumes the bench sets the levels directly and calls the tasks.
`timescale 1ns/1ns
module cswc_host_model (
	input  wire logic clk,
	input  wire logic resume_req,
	output logic      usb_enumerated,
	output logic      usb_suspend,
	output logic      bulk_in_req,
	output logic      send_now_wake_n,
	output logic      rx_pending
);
	initial begin
		usb_enumerated = 1'b0;
		usb_suspend = 1'b0;
		bulk_in_req = 1'b0;
		send_now_wake_n = 1'b1;
		rx_pending = 1'b0;
	end

	// Host leaves suspend as soon as resume is asked for
	always @(posedge clk) begin
		if (resume_req === 1'b1) begin
			usb_suspend <= 1'b0;
		end
	end

	// Held low for several edges: must still count once
	task strobe();
		@(posedge clk);
		send_now_wake_n <= 1'b0;
		repeat (3) @(posedge clk);
		send_now_wake_n <= 1'b1;
	endtask

	task bulk_in();
		@(posedge clk);
		bulk_in_req <= 1'b1;
		@(posedge clk);
		bulk_in_req <= 1'b0;
	endtask
endmodule
